// >>> logic/pst_cfg.svh
// address widths, field positions and constants of the program space access
`ifndef PST_CFG_SVH
`define PST_CFG_SVH
`define PST_PADDR_W 24
`define PST_PC_W 23
`define PST_DATA_W 16
`define PST_PWORD_W 24
`define PST_PAGE_W 8
`define PST_CFG_BIT 23
`define PST_PAGE_MSB 7
`define PST_EA_MSB 15
`define PST_WIN_LO_W 15
`define PST_BYTE_W 8
`define PST_HI_LSB 16
`define PST_RST_WORD 16'h0000
`define PST_RST_ADDR 24'h000000
`define PST_RST_PWORD 24'h000000
`define PST_RST_PAGE 8'h00
`define PST_ZERO_BYTE 8'h00
`define PST_USER_MASK 24'h7ffffe
`endif

// >>> logic/pst_pkg.sv
// types shared by the program space access block
package pst_pkg;
    typedef enum logic [1:0] {
        PST_IDLE = 2'b00,
        PST_FIRST = 2'b01,
        PST_SECOND = 2'b11
    } pst_state_t;

    typedef enum logic [1:0] {
        PST_SRC_FETCH = 2'b00,
        PST_SRC_TABLE = 2'b01,
        PST_SRC_WINDOW = 2'b10,
        PST_SRC_NONE = 2'b11
    } pst_src_t;
endpackage : pst_pkg

// >>> logic/pst_program_space_access.sv
// program space address construction and table data lane steering
// How it works
// - form 24-bit address from pc, table, window
// - program words two address units apart
// - non-table accesses stay in user range
// - table page top bit picks config space
// - bit 23 set only for config tables
// - table address is page above effective address
// - low table ops reach low 16 bits
// - only high table ops expose upper byte
// - word low read returns bits 15:0
// - byte low read picks low/high byte
// - word high read: upper byte, zero top
// - byte high read: upper byte or zero
// - window maps 16K-word page into upper data
// - window address: 0, page, low 15 bits
// - window needs ea msb and enable
// - window access stalls two cycles
// - window suspended during table ops
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "pst_cfg.svh"
module pst_program_space_access
    import pst_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // core requests
    input wire logic fetchReq,
    input wire logic [`PST_PC_W-1:0] programCounter,
    input wire logic tableReadLow,
    input wire logic tableReadHigh,
    input wire logic tableWriteLow,
    input wire logic tableWriteHigh,
    input wire logic byteMode,
    input wire logic dataReq,
    input wire logic [`PST_DATA_W-1:0] effectiveAddress,
    input wire logic [`PST_DATA_W-1:0] writeData,
    input wire logic [`PST_PAGE_W-1:0] tablePageRegister,
    input wire logic [`PST_PAGE_W-1:0] windowPageRegister,
    input wire logic programWindowEnable,
    // program memory side
    input wire logic [`PST_PWORD_W-1:0] memReadData,
    output logic [`PST_PADDR_W-1:0] memAddr,
    output logic memRead,
    output logic memWrite,
    output logic [`PST_PWORD_W-1:0] memWriteData,
    output logic [2:0] memLaneEnable,
    // core answers
    output logic [`PST_DATA_W-1:0] readData,
    output logic readValid,
    output logic windowHit,
    output logic coreStall,
    output logic configAccess
);

    pst_state_t state_q;
    pst_src_t src_q;
    logic tableHigh_q;
    logic byteMode_q;
    logic byteSel_q;
    logic [`PST_PADDR_W-1:0] memAddr_q;
    logic memRead_q;
    logic memWrite_q;
    logic [`PST_PWORD_W-1:0] memWriteData_q;
    logic [2:0] memLane_q;
    logic [`PST_DATA_W-1:0] readData_q;
    logic readValid_q;
    logic windowHit_q;
    logic coreStall_q;
    logic configAccess_q;

    logic tableAny;
    logic tableRead;
    logic tableWrite;
    logic tableHighReq;
    logic windowReq;
    logic [`PST_PADDR_W-1:0] addr_d;
    pst_src_t src_d;

    // steer a program word onto the 16-bit data lanes
    function automatic logic [`PST_DATA_W-1:0] pst_lane_read(
        input logic [`PST_PWORD_W-1:0] pw,
        input logic high,
        input logic isByte,
        input logic sel
    );
        logic [`PST_DATA_W-1:0] r;
        r = `PST_RST_WORD;
        if (!high) begin
            if (!isByte) begin
                r = pw[`PST_DATA_W-1:0];
            end else if (!sel) begin
                r[`PST_BYTE_W-1:0] = pw[`PST_BYTE_W-1:0];
            end else begin
                r[`PST_BYTE_W-1:0] = pw[`PST_DATA_W-1:`PST_BYTE_W];
            end
        end else begin
            if (!isByte || !sel) begin
                r[`PST_BYTE_W-1:0] = pw[`PST_PWORD_W-1:`PST_HI_LSB];
            end else begin
                r[`PST_BYTE_W-1:0] = `PST_ZERO_BYTE;
            end
        end
        return r;
    endfunction : pst_lane_read

    assign tableRead = tableReadLow | tableReadHigh;
    assign tableWrite = tableWriteLow | tableWriteHigh;
    assign tableAny = tableRead | tableWrite;
    assign tableHighReq = tableReadHigh | tableWriteHigh;
    assign windowReq = dataReq & programWindowEnable
        & effectiveAddress[`PST_EA_MSB] & ~tableAny;

    // address source select
    always_comb begin
        addr_d = `PST_RST_ADDR;
        src_d = PST_SRC_NONE;
        if (tableAny) begin
            addr_d = {tablePageRegister, effectiveAddress};
            src_d = PST_SRC_TABLE;
        end else if (windowReq) begin
            addr_d = {1'b0, windowPageRegister,
                effectiveAddress[`PST_WIN_LO_W-1:0]};
            src_d = PST_SRC_WINDOW;
        end else if (fetchReq) begin
            addr_d = {1'b0, programCounter[`PST_PC_W-1:1], 1'b0};
            src_d = PST_SRC_FETCH;
        end
        // the window keeps ea bit 0 as byte select; its bit 23 is already 0
        if (src_d == PST_SRC_FETCH) begin
            addr_d = addr_d & `PST_USER_MASK;
        end
    end

    // access sequencer; window accesses take two memory cycles
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PST_IDLE;
        end else begin
            case (state_q)
                PST_IDLE: begin
                    if (windowReq) begin
                        state_q <= PST_FIRST;
                    end
                end
                PST_FIRST: begin
                    state_q <= PST_SECOND;
                end
                PST_SECOND: begin
                    state_q <= PST_IDLE;
                end
                default: begin
                    state_q <= PST_IDLE;
                end
            endcase
        end
    end

    // request capture and memory drive
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_q <= PST_SRC_NONE;
            tableHigh_q <= 1'b0;
            byteMode_q <= 1'b0;
            byteSel_q <= 1'b0;
            memAddr_q <= `PST_RST_ADDR;
            memRead_q <= 1'b0;
            memWrite_q <= 1'b0;
            memWriteData_q <= `PST_RST_PWORD;
            memLane_q <= 3'h0;
            configAccess_q <= 1'b0;
        end else if (state_q == PST_IDLE) begin
            src_q <= src_d;
            tableHigh_q <= tableHighReq;
            byteMode_q <= byteMode;
            byteSel_q <= effectiveAddress[0];
            memAddr_q <= addr_d;
            memRead_q <= (src_d != PST_SRC_NONE) & ~tableWrite;
            memWrite_q <= tableWrite;
            configAccess_q <= tableAny & tablePageRegister[`PST_PAGE_MSB];
            memWriteData_q <= `PST_RST_PWORD;
            memLane_q <= 3'h0;
            if (tableWriteLow) begin
                if (!byteMode) begin
                    memWriteData_q[`PST_DATA_W-1:0] <= writeData;
                    memLane_q <= 3'h3;
                end else if (!effectiveAddress[0]) begin
                    memWriteData_q[`PST_BYTE_W-1:0] <= writeData[`PST_BYTE_W-1:0];
                    memLane_q <= 3'h1;
                end else begin
                    memWriteData_q[`PST_DATA_W-1:`PST_BYTE_W] <=
                        writeData[`PST_BYTE_W-1:0];
                    memLane_q <= 3'h2;
                end
            end else if (tableWriteHigh) begin
                // byte select 1 has no lane
                memWriteData_q[`PST_PWORD_W-1:`PST_HI_LSB] <=
                    writeData[`PST_BYTE_W-1:0];
                memLane_q <= (byteMode && effectiveAddress[0]) ? 3'h0 : 3'h4;
            end else if (src_d != PST_SRC_NONE) begin
                memLane_q <= 3'h7;
            end
        end else begin
            memWrite_q <= 1'b0;
            memLane_q <= (state_q == PST_FIRST) ? 3'h7 : 3'h0;
            memRead_q <= (state_q == PST_FIRST);
            configAccess_q <= 1'b0;
        end
    end

    // read data return, stall and window flag
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_q <= `PST_RST_WORD;
            readValid_q <= 1'b0;
            windowHit_q <= 1'b0;
            coreStall_q <= 1'b0;
        end else begin
            readValid_q <= 1'b0;
            readData_q <= `PST_RST_WORD;
            coreStall_q <= windowReq & (state_q == PST_IDLE)
                | (state_q == PST_FIRST);
            windowHit_q <= (state_q == PST_IDLE) ? windowReq : windowHit_q
                & (state_q != PST_SECOND);
            if (state_q == PST_IDLE && memRead_q) begin
                if (src_q == PST_SRC_TABLE) begin
                    readData_q <= pst_lane_read(memReadData, tableHigh_q,
                        byteMode_q, byteSel_q);
                    readValid_q <= 1'b1;
                end else if (src_q == PST_SRC_FETCH) begin
                    readValid_q <= 1'b0;
                end
            end else if (state_q == PST_SECOND) begin
                // only the low word reaches data space
                readData_q <= memReadData[`PST_DATA_W-1:0];
                readValid_q <= 1'b1;
            end
        end
    end

    assign memAddr = memAddr_q;
    assign memRead = memRead_q;
    assign memWrite = memWrite_q;
    assign memWriteData = memWriteData_q;
    assign memLaneEnable = memLane_q;
    assign readData = readData_q;
    assign readValid = readValid_q;
    assign windowHit = windowHit_q;
    assign coreStall = coreStall_q;
    assign configAccess = configAccess_q;

    AST_USER_RANGE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && src_d != PST_SRC_TABLE
            && src_d != PST_SRC_NONE)
        |=> memAddr[`PST_CFG_BIT] == 1'b0)
        else $error("non-table address left user range");

    AST_CFG_BIT: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && tableAny)
        |=> (memAddr[`PST_CFG_BIT] == $past(tablePageRegister[`PST_PAGE_MSB])
            && configAccess == $past(tablePageRegister[`PST_PAGE_MSB])))
        else $error("config bit does not follow table page");

    AST_TABLE_ADDR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && tableAny)
        |=> memAddr == {$past(tablePageRegister), $past(effectiveAddress)})
        else $error("table address not page over address");

    AST_WINDOW_ADDR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && windowReq)
        |=> memAddr == {1'b0, $past(windowPageRegister),
            $past(effectiveAddress[`PST_WIN_LO_W-1:0])})
        else $error("window address wrong");

    AST_WINDOW_STALL: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && windowReq)
        |=> coreStall [*2] ##1 readValid)
        else $error("window access did not stall");

    AST_NO_WIN_IN_TABLE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && tableAny) |=> !windowHit)
        else $error("window active during table op");

    AST_WIN_NEEDS_EN: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && !programWindowEnable) |=> !windowHit)
        else $error("window used while disabled");

    AST_HIGH_TOP_ZERO: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && memRead_q && src_q == PST_SRC_TABLE
            && tableHigh_q)
        |=> readData[`PST_DATA_W-1:`PST_BYTE_W] == `PST_ZERO_BYTE)
        else $error("high read exposed nonzero top byte");

    AST_FETCH_ALIGN: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q == PST_IDLE && !tableAny && !windowReq && fetchReq)
        |=> (memAddr[`PST_PC_W-1:1] == $past(programCounter[`PST_PC_W-1:1])
            && memAddr[0] == 1'b0 && memAddr[`PST_CFG_BIT] == 1'b0))
        else $error("fetch address not from pc");

endmodule : pst_program_space_access

// >>> testbench/pst_mem_model.sv
// program memory model answering a read in the cycle of the request
`timescale 1ns/100ps
module pst_mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // memory port
    input wire logic [23:0] memAddr,
    input wire logic memRead,
    output logic [23:0] memReadData
);
    logic [23:0] lastWord_q;
    function automatic logic [23:0] pat(input logic [23:0] a);
        return {a[7:0] ^ 8'h5a, a[23:16] ^ 8'hc3, a[15:8] ^ 8'h96};
    endfunction : pat
    // an idle port shows the inverse of the last word, never a stale copy
    assign memReadData = memRead ? pat(memAddr) : ~lastWord_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lastWord_q <= 24'h000000;
        end else if (memRead) begin
            lastWord_q <= pat(memAddr);
        end
    end
endmodule : pst_mem_model

// >>> testbench/test_program_space_table_access.sv
// self-checking bench for the program space access block
`timescale 1ns/100ps
module test_program_space_table_access;
    logic sys_clk, reset_n, fetchReq, dataReq, byteMode, programWindowEnable;
    logic tableReadLow, tableReadHigh, tableWriteLow, tableWriteHigh;
    logic [22:0] programCounter;
    logic [15:0] effectiveAddress, writeData;
    logic [7:0] tablePageRegister, windowPageRegister;
    logic [23:0] memReadData, memAddr, memWriteData;
    logic memRead, memWrite, readValid, windowHit, coreStall, configAccess;
    logic [2:0] memLaneEnable;
    logic [15:0] readData;
    int fail_count, tests_run;

    pst_program_space_access i_pst_program_space_access (.sys_clk, .reset_n,
        .fetchReq, .programCounter, .tableReadLow, .tableReadHigh,
        .tableWriteLow, .tableWriteHigh, .byteMode, .dataReq,
        .effectiveAddress, .writeData, .tablePageRegister, .windowPageRegister,
        .programWindowEnable, .memReadData, .memAddr, .memRead, .memWrite,
        .memWriteData, .memLaneEnable, .readData, .readValid, .windowHit,
        .coreStall, .configAccess);
    pst_mem_model i_pst_mem_model (.sys_clk, .reset_n, .memAddr, .memRead,
        .memReadData);

    task chk(input string n, input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // k = {enable, byte, fetch, data, wrHigh, wrLow, rdHigh, rdLow}
    task issue(input logic [7:0] k, input logic [15:0] ea,
               input logic [7:0] pg);
        @(posedge sys_clk);
        {programWindowEnable, byteMode, fetchReq, dataReq, tableWriteHigh,
         tableWriteLow, tableReadHigh, tableReadLow} <= k;
        effectiveAddress <= ea;
        writeData <= ~ea;
        tablePageRegister <= pg;
        windowPageRegister <= pg;
        programCounter <= {pg[6:0], ea};
        @(posedge sys_clk);
        {fetchReq, dataReq, tableWriteHigh, tableWriteLow, tableReadHigh,
         tableReadLow} <= 6'h00;
        #1;
    endtask : issue

    task t_fetch;
        issue(8'h20, 16'hffff, 8'hff);
        chk("faddr", memAddr, 24'h7ffffe);
        chk("fcfg", configAccess, 1'b0);
        chk("frd", memRead, 1'b1);
        issue(8'h20, 16'h0003, 8'h80);
        chk("faddr2", memAddr, 24'h000002);
        @(posedge sys_clk);
        #1;
        chk("fvalid", readValid, 1'b0);
        $display("done fetch");
    endtask : t_fetch

    // table reads collide with a window request to show table priority
    task t_table_read;
        logic [23:0] a, w;
        logic [15:0] e, s;
        logic hi, by, sel;
        for (int i = 0; i < 16; i++) begin
            {hi, by, sel} = {i[0], i[1], i[2]};
            issue({2'b10, 2'b01, 2'b00, hi, ~hi} | {1'b0, by, 6'h00},
                  16'h9a30 | 16'(sel), {i[3], 7'h2b});
            a = {i[3], 7'h2b, 16'h9a30 | 16'(sel)};
            w = i_pst_mem_model.pat(a);
            chk("taddr", memAddr, a);
            chk("tcfg", configAccess, i[3]);
            chk("thit", windowHit, 1'b0);
            @(posedge sys_clk);
            #1;
            chk("tvalid", readValid, 1'b1);
            if (!hi) begin
                e = by ? (sel ? 16'(w[15:8]) : 16'(w[7:0])) : w[15:0];
            end else begin
                e = (by && sel) ? 16'h0000 : 16'(w[23:16]);
            end
            s = by ? {8'h00, readData[7:0]} : readData;
            chk("tdata", s, e);
        end
        $display("done table read");
    endtask : t_table_read

    task t_table_write;
        logic hi, by, sel;
        logic [15:0] ea;
        logic [2:0] ln;
        logic [23:0] ewd;
        for (int i = 0; i < 8; i++) begin
            {hi, by, sel} = {i[0], i[1], i[2]};
            ea = 16'h4c60 | 16'(sel);
            issue({1'b0, by, 2'b00, hi, ~hi, 2'b00}, ea, 8'h91);
            ln = hi ? ((by && sel) ? 3'h0 : 3'h4) : (by ? {sel, ~sel, 1'b0}
                 >> 1 : 3'h3);
            chk("wstb", memWrite, 1'b1);
            chk("waddr", memAddr, {8'h91, ea});
            chk("wlane", memLaneEnable, ln);
            if (hi) begin
                ewd = {~ea[7:0], 16'h0000};
            end else if (!by) begin
                ewd = {8'h00, ~ea};
            end else if (sel) begin
                ewd = {8'h00, ~ea[7:0], 8'h00};
            end else begin
                ewd = {16'h0000, ~ea[7:0]};
            end
            if (ln != 3'h0) begin
                chk("wdata", memWriteData, ewd);
            end
        end
        $display("done table write");
    endtask : t_table_write

    task t_window;
        logic [23:0] w;
        w = i_pst_mem_model.pat({1'b0, 8'h5e, 15'h4123});
        issue(8'h90, 16'hc123, 8'h5e);
        chk("waddr", memAddr, {1'b0, 8'h5e, 15'h4123});
        chk("whit", {windowHit, coreStall, memRead}, 3'h7);
        @(posedge sys_clk);
        #1;
        chk("wstall", {coreStall, memRead}, 2'h3);
        @(posedge sys_clk);
        #1;
        chk("wdone", {readValid, coreStall}, 2'h2);
        chk("wrdata", readData, w[15:0]);
        issue(8'h10, 16'hc123, 8'h5e);
        chk("woff", {windowHit, coreStall}, 2'h0);
        issue(8'h90, 16'h4123, 8'h5e);
        chk("wlow", {windowHit, coreStall}, 2'h0);
        $display("done window");
    endtask : t_window

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        #(3000 * 100);
        fail_count++;
        $display("mismatch watchdog expected finish seen hang");
        report_and_stop();
    end

    initial begin
        {fetchReq, dataReq, byteMode, programWindowEnable} = 4'h0;
        {tableReadLow, tableReadHigh, tableWriteLow, tableWriteHigh} = 4'h0;
        {programCounter, effectiveAddress, writeData} = 55'h0;
        {tablePageRegister, windowPageRegister} = 16'h0000;
        fail_count = 0;
        tests_run = 0;
        reset_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        chk("rst", {readValid, coreStall, windowHit, memRead}, 4'h0);
        t_fetch();
        t_table_read();
        t_table_write();
        t_window();
        report_and_stop();
    end
endmodule : test_program_space_table_access
